/* File: verilog/tkt_pkg.sv */
/*
 * Shared constants and types for the transmit key timers block:
 * tick timing, setting step sizes, limits and the state record.
 * Assumes a single 250 MHz system clock and an active-low async reset.
 */
package tkt_pkg;

    // ****************************************************************
    // Clock and tick timing
    // ****************************************************************
    localparam int unsigned CLK_MHZ      = 250;            // System clock rate
    localparam int unsigned TICK_MS      = 20;             // Common timer tick period
    localparam int unsigned TICK_CYCLES  = TICK_MS * 1000 * CLK_MHZ;
    localparam int unsigned TICK_CNT_W   = 32;

    // ****************************************************************
    // Setting steps and limits, in milliseconds and seconds
    // ****************************************************************
    localparam int unsigned TAIL_STEP_MS   = 100;          // Coarse tail step
    localparam int unsigned FINE_STEP_MS   = 20;           // Fine tail and timeout step
    localparam int unsigned TAIL_MAX_S     = 5;
    localparam int unsigned TO_STEP_S      = 10;           // Timeout step
    localparam int unsigned TO_MAX_S       = 300;
    localparam int unsigned LO_STEP_S      = 10;           // Lockout step
    localparam int unsigned LO_MAX_S       = 60;

    // ****************************************************************
    // The same figures as tick counts
    // ****************************************************************
    localparam int unsigned CNT_W = 14;
    localparam logic [CNT_W-1:0] TAIL_STEP_TICKS = CNT_W'(TAIL_STEP_MS / TICK_MS);
    localparam logic [CNT_W-1:0] FINE_STEP_TICKS = CNT_W'(FINE_STEP_MS / TICK_MS);
    localparam logic [CNT_W-1:0] TO_STEP_TICKS   = CNT_W'(TO_STEP_S * 1000 / TICK_MS);
    localparam logic [CNT_W-1:0] LO_STEP_TICKS   = CNT_W'(LO_STEP_S * 1000 / TICK_MS);
    localparam logic [CNT_W-1:0] TAIL_MAX_TICKS  = CNT_W'(TAIL_MAX_S * 1000 / TICK_MS);
    localparam logic [CNT_W-1:0] TO_MAX_TICKS    = CNT_W'(TO_MAX_S * 1000 / TICK_MS);
    localparam logic [CNT_W-1:0] LO_MAX_TICKS    = CNT_W'(LO_MAX_S * 1000 / TICK_MS);

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef enum logic [2:0] {
        TKT_IDLE,
        TKT_KEYED,
        TKT_TAIL,
        TKT_LOCKOUT,
        TKT_WAIT_RELEASE
    } tkt_state_t;

    typedef struct packed {
        tkt_state_t       state;
        logic [CNT_W-1:0] tx_cnt;        // Ticks of the current transmission
        logic [CNT_W-1:0] ph_cnt;        // Ticks in tail or lockout
        logic             tx_enable;
        logic             lockout_active;
        logic             timed_out;
    } tkt_st_t;

    localparam tkt_st_t TKT_RESET_ST = '{state: TKT_IDLE, default: '0};

endpackage

/* File: verilog/tkt_tick_gen.sv */
/*
 * Periodic tick generator: one-cycle pulse every TICK_CYCLES clocks.
 * Assumes the system clock and async active-low reset of the timers.
 */
module tkt_tick_gen #(
    parameter int unsigned TICK_CYCLES = tkt_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Tick out
    output logic      tick
);

    typedef struct packed {
        logic [tkt_pkg::TICK_CNT_W-1:0] cnt;
        logic                           tick;
    } tkt_tick_st_t;

    tkt_tick_st_t st;
    tkt_tick_st_t next_st;

    // ****************************************************************
    // Divider
    // ****************************************************************
    // Counts down so the terminal test is a compare against zero
    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == '0)
        begin
            next_st.cnt  = tkt_pkg::TICK_CNT_W'(TICK_CYCLES - 1);
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick = st.tick;

endmodule // tkt_tick_gen

/* File: verilog/tkt_timers.sv */
/*
 * Transmit key timers: tail, timeout and lockout timing of the
 * transmitter enable from an earthed (active-low) key line.
 * Assumes key and settings are synchronous to clk; settings are held
 * stable by configuration logic while in use.
 */

// Operation
// RULE_01: On key release keep transmitting for the tail time, then drop.
// RULE_02: Coarse tail setting spans 0 to 5 s in 100 ms steps.
// RULE_03: Timeout, 0 to 300 s in 10 s steps, ends a continuous transmission.
// RULE_04: After timeout, key must be released and asserted again to transmit.
// RULE_05: After timeout, key requests are ignored for the lockout period.
// RULE_06: When lockout has elapsed a fresh key enables the transmitter again.
// RULE_07: Fine mode sets tail and timeout in 20 ms steps.
// RULE_08: All timers count a common clock-derived tick and clear on reset.
module tkt_timers #(
    parameter int unsigned TICK_CYCLES = tkt_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // Key line, low while earthed
    input  wire logic                     tx_key_n,
    // Settings
    input  wire logic                     fine_mode,
    input  wire logic [7:0]               tail_set,
    input  wire logic [tkt_pkg::CNT_W-1:0] timeout_set,
    input  wire logic [2:0]               lockout_set,
    // Status
    output logic                          tx_enable,
    output logic                          lockout_active,
    output logic                          timed_out
);

    localparam int unsigned W = tkt_pkg::CNT_W;

    tkt_pkg::tkt_st_t st;
    tkt_pkg::tkt_st_t next_st;
    logic             tick;
    logic             key;
    logic [W-1:0]     tail_ticks;
    logic [W-1:0]     timeout_ticks;
    logic [W-1:0]     lockout_ticks;
    logic             to_expired;

    // ****************************************************************
    // Tick source
    // ****************************************************************
    tkt_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk    (clk),
        .resetn (resetn),
        .tick   (tick)
    );

    // ****************************************************************
    // Setting decode
    // ****************************************************************
    // Out-of-range settings clamp to the largest legal time
    function automatic logic [W-1:0] to_ticks(
        input logic [W-1:0] steps,
        input logic [W-1:0] mult,
        input logic [W-1:0] lim
    );
        logic [2*W-1:0] p;
        p = steps * mult;
        if (p > {{W{1'b0}}, lim})
            to_ticks = lim;
        else
            to_ticks = p[W-1:0];
    endfunction

    assign key = ~tx_key_n;

    // Fine mode reinterprets the tail and timeout fields as 20 ms steps
    always_comb
    begin
        if (fine_mode)
        begin
            tail_ticks    = to_ticks(W'(tail_set), tkt_pkg::FINE_STEP_TICKS,
                                     tkt_pkg::TAIL_MAX_TICKS);              // RULE_07
            timeout_ticks = to_ticks(timeout_set, tkt_pkg::FINE_STEP_TICKS,
                                     tkt_pkg::TO_MAX_TICKS);                // RULE_07
        end
        else
        begin
            tail_ticks    = to_ticks(W'(tail_set), tkt_pkg::TAIL_STEP_TICKS,
                                     tkt_pkg::TAIL_MAX_TICKS);              // RULE_02
            timeout_ticks = to_ticks(timeout_set, tkt_pkg::TO_STEP_TICKS,
                                     tkt_pkg::TO_MAX_TICKS);                // RULE_03
        end
        lockout_ticks = to_ticks(W'(lockout_set), tkt_pkg::LO_STEP_TICKS,
                                 tkt_pkg::LO_MAX_TICKS);                    // RULE_05
    end

    // A zero timeout setting means no limit
    assign to_expired = (timeout_ticks != '0) && (st.tx_cnt >= timeout_ticks); // RULE_03

    // ****************************************************************
    // Keying state machine
    // ****************************************************************
    // Phases start on any clock, so each time is exact to one tick
    always_comb
    begin
        next_st = st;
        case (st.state)
            tkt_pkg::TKT_IDLE:
            begin
                if (key)
                begin
                    next_st.state  = tkt_pkg::TKT_KEYED;                    // RULE_06
                    next_st.tx_cnt = '0;
                end
            end
            tkt_pkg::TKT_KEYED, tkt_pkg::TKT_TAIL:
            begin
                // Tail time still counts toward the transmission limit
                if (tick)
                    next_st.tx_cnt = st.tx_cnt + 1'b1;                      // RULE_08
                if (to_expired)
                begin
                    next_st.ph_cnt = '0;
                    if (lockout_ticks != '0)
                        next_st.state = tkt_pkg::TKT_LOCKOUT;               // RULE_05
                    else
                        next_st.state = tkt_pkg::TKT_WAIT_RELEASE;          // RULE_04
                end
                else if (key)
                begin
                    next_st.state = tkt_pkg::TKT_KEYED;
                end
                else if (st.state == tkt_pkg::TKT_KEYED)
                begin
                    next_st.ph_cnt = '0;
                    if (tail_ticks != '0)
                        next_st.state = tkt_pkg::TKT_TAIL;                  // RULE_01
                    else
                        next_st.state = tkt_pkg::TKT_IDLE;
                end
                else if (st.ph_cnt >= tail_ticks)
                begin
                    next_st.state = tkt_pkg::TKT_IDLE;                      // RULE_01
                end
                else if (tick)
                begin
                    next_st.ph_cnt = st.ph_cnt + 1'b1;
                end
            end
            tkt_pkg::TKT_LOCKOUT:
            begin
                // Key is not looked at until the lockout has run out
                if (st.ph_cnt >= lockout_ticks)
                    next_st.state = tkt_pkg::TKT_WAIT_RELEASE;              // RULE_06
                else if (tick)
                    next_st.ph_cnt = st.ph_cnt + 1'b1;                      // RULE_05
            end
            tkt_pkg::TKT_WAIT_RELEASE:
            begin
                if (!key)
                    next_st.state = tkt_pkg::TKT_IDLE;                      // RULE_04
            end
            default:
            begin
                next_st.state = tkt_pkg::TKT_IDLE;
            end
        endcase
        // Outputs are decoded from the next state so they leave a flop
        next_st.tx_enable      = (next_st.state == tkt_pkg::TKT_KEYED) ||
                                 (next_st.state == tkt_pkg::TKT_TAIL);
        next_st.lockout_active = (next_st.state == tkt_pkg::TKT_LOCKOUT);
        next_st.timed_out      = (next_st.state == tkt_pkg::TKT_LOCKOUT) ||
                                 (next_st.state == tkt_pkg::TKT_WAIT_RELEASE);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            st <= tkt_pkg::TKT_RESET_ST;                                    // RULE_08
        else
            st <= next_st;
    end

    assign tx_enable      = st.tx_enable;
    assign lockout_active = st.lockout_active;
    assign timed_out      = st.timed_out;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_tail_starts: assert property (                                        // RULE_01
        (st.state == tkt_pkg::TKT_KEYED && !key && !to_expired && tail_ticks != '0)
        |=> (tx_enable && st.state == tkt_pkg::TKT_TAIL && st.ph_cnt == '0))
        else $error("Tail did not start on key release");

    a_tail_ends: assert property (                                          // RULE_01
        (st.state == tkt_pkg::TKT_TAIL && !key && !to_expired && st.ph_cnt >= tail_ticks)
        |=> !tx_enable)
        else $error("Tail did not end when its time ran out");

    a_tail_range: assert property (                                         // RULE_02
        !fine_mode |-> (tail_ticks <= tkt_pkg::TAIL_MAX_TICKS &&
                        (tail_set > 8'h32 || tail_ticks == W'(tail_set) * 5)))
        else $error("Coarse tail decode wrong");

    a_timeout_cut: assert property (                                        // RULE_03
        (tx_enable && to_expired) |=> (!tx_enable && timed_out))
        else $error("Transmission ran past its timeout");

    a_rekey_need: assert property (                                         // RULE_04
        (st.state == tkt_pkg::TKT_WAIT_RELEASE && key) |=> !tx_enable)
        else $error("Transmitted without a fresh key");

    a_lockout_hold: assert property (                                       // RULE_05
        $rose(lockout_active) |-> (!tx_enable && lockout_active)[*8])
        else $error("Lockout did not hold the transmitter off");

    a_fresh_key: assert property (                                          // RULE_06
        (st.state == tkt_pkg::TKT_IDLE && key) |=> (tx_enable && st.tx_cnt == '0))
        else $error("Fresh key did not enable the transmitter");

    a_fine_steps: assert property (                                         // RULE_07
        (fine_mode && tail_set <= 8'hfa) |-> (tail_ticks == W'(tail_set)))
        else $error("Fine tail decode wrong");

    a_tick_only: assert property (                                          // RULE_08
        // The count at this edge follows the tick of the cycle before it
        (!$past(tick) && st.state == tkt_pkg::TKT_KEYED && $stable(st.state))
        |-> (st.tx_cnt == $past(st.tx_cnt)))
        else $error("Transmission counter moved without a tick");

endmodule // tkt_timers

/* File: sim/tkt_key_src.sv */
/*
 * Behavioural transmit key source: an earthed key line, pulled up while open.
 * Assumes the bench raises its request synchronously to clk.
 */
module tkt_key_src (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Request from the bench
    input  wire logic press,
    // Key line, low while earthed
    output logic      tx_key_n
);
    timeunit 1ns;
    timeprecision 100ps;

    // Line follows the request one clock later; an open switch reads high
    // because of the pull-up, so there is no floating level to model.
    // Resuming after a timeout takes an explicit release, then a new press.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            tx_key_n <= 1'b1;
        else
            tx_key_n <= !press;
    end
endmodule // tkt_key_src

/* File: sim/test_transmit_key_timers.sv */
/*
 * Self-checking bench of the transmit key timers with a behavioural key source.
 * Assumes a short tick of ten clocks so that every interval fits the run.
 */
module test_transmit_key_timers;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Signals
    // ****************************************************************
    localparam int TK = 10;  // Clocks per tick
    logic                      clk;
    logic                      resetn;
    logic                      press;
    logic                      tx_key_n;
    logic                      fine_mode;
    logic [7:0]                tail_set;
    logic [tkt_pkg::CNT_W-1:0] timeout_set;
    logic [2:0]                lockout_set;
    logic                      tx_enable;
    logic                      lockout_active;
    logic                      timed_out;
    int                        n_mismatch = 0;
    int                        cmp_count = 0;
    int                        n;

    tkt_key_src i_key (.clk(clk), .resetn(resetn), .press(press), .tx_key_n(tx_key_n));

    tkt_timers #(.TICK_CYCLES(TK)) i_dut (
        .clk(clk), .resetn(resetn), .tx_key_n(tx_key_n), .fine_mode(fine_mode),
        .tail_set(tail_set), .timeout_set(timeout_set), .lockout_set(lockout_set),
        .tx_enable(tx_enable), .lockout_active(lockout_active), .timed_out(timed_out));

    // Clock at 250 MHz
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
            $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
        if (got !== exp)
            n_mismatch++;
    endtask

    // Durations are judged in a window: phases start unaligned to the tick
    task automatic chk_rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi)
        begin
            n_mismatch++;
            $display("unexpected span at %0t: got %h, window %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic key(input logic v);
        @(posedge clk);
        press <= v;
    endtask

    task automatic cyc(input int c);
        repeat (c) @(negedge clk);
    endtask

    task automatic cfg(input logic f, input int t, input int o, input int l);
        @(posedge clk);
        fine_mode   <= f;
        tail_set    <= t[7:0];
        timeout_set <= o[tkt_pkg::CNT_W-1:0];
        lockout_set <= l[2:0];
    endtask

    // Counts clocks until the chosen output reaches lvl; a stuck output ends the run
    task automatic wait_lvl(input bit lo_sel, input logic lvl, input int bound, output int c);
        c = 0;
        while ((lo_sel ? lockout_active : tx_enable) !== lvl)
        begin
            @(negedge clk);
            c++;
            if (c > bound)
            begin
                n_mismatch++;
                $display("unexpected timeout at %0t: got %h, expected %h", $time, !lvl, lvl);
                end_of_test();
            end
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        cyc(2);
        chk({tx_enable, lockout_active, timed_out}, 32'h0);
        key(1'b1);
        wait_lvl(0, 1'b1, 8, n);
        @(posedge clk);
        resetn <= 1'b0;
        cyc(1);
        chk({tx_enable, lockout_active, timed_out}, 32'h0);
        key(1'b0);
        @(posedge clk);
        resetn <= 1'b1;
        cyc(3);
        chk({tx_enable, lockout_active, timed_out}, 32'h0);
        $display("test reset done");
    endtask

    // Coarse and fine tails, zero, maximum and a clamped setting
    task automatic t_tail;
        int tb [7][3] = '{'{1, 5, 5}, '{0, 1, 5}, '{0, 2, 10}, '{1, 0, 0},
                          '{0, 50, 250}, '{0, 60, 250}, '{1, 255, 250}};
        foreach (tb[i])
        begin
            cfg(tb[i][0], tb[i][1], 0, 0);
            key(1'b1);
            wait_lvl(0, 1'b1, 8, n);
            chk(tx_enable, 1'b1);
            cyc(20);
            key(1'b0);
            wait_lvl(0, 1'b0, 3000, n);
            chk_rng(n, tb[i][2] * TK - TK, tb[i][2] * TK + 14);
            cyc(4);
        end
        $display("test tail done");
    endtask

    // A re-key inside the tail continues the transmission with no drop
    task automatic t_glitch;
        cfg(1, 5, 0, 0);
        key(1'b1);
        wait_lvl(0, 1'b1, 8, n);
        key(1'b0);
        cyc(20);
        key(1'b1);
        cyc(60);
        chk(tx_enable, 1'b1);
        key(1'b0);
        wait_lvl(0, 1'b0, 80, n);
        $display("test glitch done");
    endtask

    // Fine timeout with no lockout; held key stays refused until re-keyed
    task automatic t_timeout;
        cfg(1, 0, 10, 0);
        key(1'b1);
        wait_lvl(0, 1'b1, 8, n);
        wait_lvl(0, 1'b0, 300, n);
        chk_rng(n, 9 * TK, 11 * TK + 4);
        chk({timed_out, lockout_active}, 32'h2);
        cyc(200);
        chk(tx_enable, 1'b0);
        key(1'b0);
        cyc(4);
        key(1'b1);
        wait_lvl(0, 1'b1, 8, n);
        chk({tx_enable, timed_out}, 32'h2);
        key(1'b0);
        wait_lvl(0, 1'b0, 8, n);
        $display("test timeout done");
    endtask

    // Coarse timeout then lockout; a key during lockout is ignored
    task automatic t_lockout;
        cfg(0, 0, 1, 1);
        key(1'b1);
        wait_lvl(0, 1'b1, 8, n);
        wait_lvl(0, 1'b0, 5200, n);
        chk_rng(n, 499 * TK, 501 * TK + 4);
        cyc(1);
        chk(lockout_active, 1'b1);
        key(1'b0);
        cyc(10);
        key(1'b1);
        cyc(20);
        chk(tx_enable, 1'b0);
        key(1'b0);
        wait_lvl(1, 1'b0, 5200, n);
        chk_rng(n, 494 * TK, 500 * TK);
        cyc(2);
        chk({timed_out, tx_enable}, 32'h0);
        key(1'b1);
        wait_lvl(0, 1'b1, 8, n);
        chk(tx_enable, 1'b1);
        key(1'b0);
        wait_lvl(0, 1'b0, 8, n);
        $display("test lockout done");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        press = 1'b0;
        resetn = 1'b0;
        fine_mode = 1'b0;
        tail_set = 8'h00;
        timeout_set = '0;
        lockout_set = 3'h0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_tail();
        t_glitch();
        t_timeout();
        t_lockout();
        end_of_test();
    end
endmodule // test_transmit_key_timers
